// ===== src/adc_seq_cfg.svh
/*
  Constants of the converter sequencer: word indices, mode codes,
  clock divider codes and conversion lengths.
  Assumes a 32-bit AHB-Lite bus, one register per aligned word.
*/
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH
// Word indices (byte address = index * 4)
`define IDX_CTRL0 4'h0
`define IDX_CTRL1 4'h1
`define IDX_CTRL2 4'h2
`define IDX_CTRL3 4'h3
`define IDX_RES0 4'h4
`define IDX_RES7 4'hb
// Operating modes
`define MODE_SINGLE 3'h0
`define MODE_REPEAT 3'h1
`define MODE_SWEEP 3'h2
`define MODE_RSWEEP0 3'h3
`define MODE_RSWEEP1 3'h4
// Converter clock divide selects, then the ratio minus one for each select
`define DIV_SEL_1 3'h0
`define DIV_SEL_2 3'h1
`define DIV_SEL_3 3'h2
`define DIV_SEL_4 3'h3
`define DIV_SEL_6 3'h4
`define DIV_SEL_8 3'h5
`define DIV_M1_1 3'h0
`define DIV_M1_2 3'h1
`define DIV_M1_3 3'h2
`define DIV_M1_4 3'h3
`define DIV_M1_6 3'h5
`define DIV_M1_8 3'h7
// Converter clock cycles per input
`define CYC_8B 7'h31
`define CYC_10B 7'h3b
`define CYC_8B_SH 7'h1c
`define CYC_10B_SH 7'h21
// Channel codes for the extended inputs
`define CH_EXT0 4'h8
`define CH_EXT1 4'h9
`define EXT_SEL_0 2'h1
`define EXT_SEL_1 2'h2
`define LAST_CH 3'h7
`endif

// ===== src/adc_seq_pkg.sv
/*
  Types of the converter sequencer: register layouts and state.
  Assumes adc_seq_cfg.svh for numeric constants.
*/
package adc_seq_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CONV} seq_state_e;
  // Control word 0, bit 0 upward: input, mode, trigger, go, divider
  typedef struct packed {
    logic [2:0] clk_div_select;
    logic conversion_go_flag;
    logic trigger_kind_select;
    logic [2:0] mode;
    logic [2:0] single_input_select;
  } ctrl0_s;
  typedef struct packed {
    logic ladder_reference_connect;
    logic res_10bit;
    logic extended_input_select_hi;
    logic extended_input_select_lo;
    logic sweep_group_select_hi;
    logic sweep_group_select_lo;
  } ctrl1_s;
  typedef struct packed {
    logic external_vs_timer_trigger;
    logic sample_hold;
  } ctrl2_s;
  typedef struct packed {
    logic dma_result_mode;
  } ctrl3_s;
  // Whole block state, registered in one place
  typedef struct packed {
    ctrl0_s c0;
    ctrl1_s c1;
    ctrl2_s c2;
    ctrl3_s c3;
    logic [7:0][9:0] res;
    seq_state_e state;
    logic [2:0] div_cnt;
    logic [6:0] tick_cnt;
    logic [3:0] chan;
    logic [2:0] idx;
    logic [2:0] oidx;
    logic prio_phase;
    logic ext_prev;
    logic phi;
    logic irq;
    logic dma_req;
    logic bus_valid;
    logic bus_wr;
    logic [3:0] bus_idx;
    logic [31:0] hrdata;
  } st_s;
endpackage

// ===== src/adc_mode_sequencer.sv
/*
  Mode sequencer of a 10-bit successive-approximation converter with
  an AHB-Lite register slave, result storage and request pulses.
  Assumes the analogue core presents its code on conv_data_in by the
  end of the conversion period, and that a DMA controller and an
  interrupt controller take the one-cycle request pulses.
*/
// How it works
// R1: single mode converts chosen input once
// R2: software trigger starts on go write
// R3: hardware trigger waits for selected event
// R4: single and sweep stop when done
// R5: repeat mode runs until go cleared
// R6: single sweep covers two to eight inputs
// R7: interrupt after sweep or single conversion
// R8: no interrupt in repeat modes without DMA
// R9: DMA mode interrupts after every conversion
// R10: DMA mode writes all results to register 0
// R11: otherwise result goes to its channel register
// R12: software avoids register 0 during DMA
// R13: repeated sweep 0 loops until go cleared
// R14: repeated sweep 1 interleaves prioritised inputs
// R15: sweep bits choose one to four priority inputs
// R16: repeated sweep 1 ignores triggers mid-conversion
// R17: repeated sweep 1 always uses eight inputs
// R18: extended inputs only in single modes
// R19: software avoids rewriting control during conversion
// R20: control 3 accessed only when stopped
// R21: ladder stays connected during conversion
// R22: other modes restart on a new trigger
// R23: result width follows resolution bit
// R24: extended inputs store into registers 0, 1
// R25: converter clock divides by 1 to 8
`timescale 1ns/10ps
`include "adc_seq_cfg.svh"
module adc_mode_sequencer
  import adc_seq_pkg::*;
#(
  parameter int N_INPUTS = 8,
  parameter int RES_W = 10
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic external_trigger_pin_in,
  input wire logic motor_timer_counter_in,
  input wire logic [9:0] conv_data_in,
  output logic conv_clock_out,
  output logic [3:0] conv_channel_out,
  output logic converting_out,
  output logic ladder_reference_connect_out,
  output logic sample_hold_out,
  output logic irq_out,
  output logic dma_req_out
);
  // The state layout is fixed to eight inputs of ten bits
  if (N_INPUTS != 8 || RES_W != 10) begin : g_bad_params
    $error("adc_mode_sequencer supports 8 inputs of 10 bits only");
  end

  //--------------------------------------------------------------
  // Helpers
  //--------------------------------------------------------------
  // Divider select to ratio minus one; unused codes fall to /8
  function automatic logic [2:0] div_m1(input logic [2:0] sel);
    unique case (sel)
      `DIV_SEL_1: div_m1 = `DIV_M1_1;
      `DIV_SEL_2: div_m1 = `DIV_M1_2;
      `DIV_SEL_3: div_m1 = `DIV_M1_3;
      `DIV_SEL_4: div_m1 = `DIV_M1_4;
      `DIV_SEL_6: div_m1 = `DIV_M1_6;
      default: div_m1 = `DIV_M1_8;
    endcase
  endfunction

  st_s st; // Registered state
  st_s next_st; // Next state
  logic [1:0] grp; // Sweep group bits
  logic [1:0] ext; // Extended input bits
  logic [2:0] sweep_last; // Last input of a sweep
  logic [2:0] prio_last; // Last prioritised input
  logic single_like; // Single or repeat mode
  logic tick; // One converter clock period done
  logic [6:0] conv_len; // Converter cycles per input
  logic conv_end; // Conversion finishes this cycle
  logic ext_fall; // Falling edge on the trigger pin
  logic trig; // Selected hardware trigger event
  logic retrig; // Trigger that aborts and restarts
  logic [9:0] res_val; // Result as it will be stored
  logic [2:0] dest; // Result register index
  logic [3:0] first_ch; // First input of a run
  logic last_of_run; // Single or sweep run complete
  logic wr_ctrl0; // Software writes control 0 now
  logic [3:0] ridx; // Read index in address phase

  //--------------------------------------------------------------
  // Combinational decode
  //--------------------------------------------------------------
  always_comb begin
    grp = {st.c1.sweep_group_select_hi, st.c1.sweep_group_select_lo};
    ext = {st.c1.extended_input_select_hi, st.c1.extended_input_select_lo};
    // Groups of 2, 4, 6 or 8 inputs from input 0 [R6]
    sweep_last = {grp, 1'b1};
    // One to four prioritised inputs in repeated sweep 1 [R15]
    prio_last = {1'b0, grp};
    single_like = st.c0.mode == `MODE_SINGLE || st.c0.mode == `MODE_REPEAT;
    tick = st.div_cnt == div_m1(st.c0.clk_div_select); // [R25]
    // Period per input depends on resolution and sample-hold
    if (st.c2.sample_hold) begin
      conv_len = st.c1.res_10bit ? `CYC_10B_SH : `CYC_8B_SH;
    end else begin
      conv_len = st.c1.res_10bit ? `CYC_10B : `CYC_8B;
    end
    conv_end = st.state == ST_CONV && tick && st.tick_cnt == conv_len - 7'h01;
    ext_fall = st.ext_prev && !external_trigger_pin_in;
    trig = st.c2.external_vs_timer_trigger ? motor_timer_counter_in : ext_fall; // [R3]
    // Mid-conversion triggers restart, except in repeated sweep 1
    retrig = st.state == ST_CONV && st.c0.trigger_kind_select && trig
      && st.c0.mode != `MODE_RSWEEP1; // [R16] [R22]
    // 8-bit results sit in bits 7 to 0 [R23]
    res_val = st.c1.res_10bit ? conv_data_in : {2'h0, conv_data_in[9:2]};
    if (st.c3.dma_result_mode) begin
      dest = 3'h0; // [R10]
    end else if (st.chan == `CH_EXT0) begin
      dest = 3'h0; // [R24]
    end else if (st.chan == `CH_EXT1) begin
      dest = 3'h1; // [R24]
    end else begin
      dest = st.chan[2:0]; // [R11]
    end
    // Single modes take the chosen input, sweeps start at input 0
    if (!single_like) begin
      first_ch = 4'h0; // [R6]
    end else if (ext == `EXT_SEL_0) begin
      first_ch = `CH_EXT0;
    end else if (ext == `EXT_SEL_1) begin
      first_ch = `CH_EXT1;
    end else begin
      first_ch = {1'b0, st.c0.single_input_select}; // [R1]
    end
    last_of_run = st.c0.mode == `MODE_SINGLE
      || (st.c0.mode == `MODE_SWEEP && st.idx == sweep_last);
    wr_ctrl0 = st.bus_valid && st.bus_wr && st.bus_idx == `IDX_CTRL0;
    ridx = haddr_in[5:2];
  end

  //--------------------------------------------------------------
  // Next-state logic: divider, sequencer, bus
  //--------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.irq = 1'b0;
    next_st.dma_req = 1'b0;
    next_st.ext_prev = external_trigger_pin_in;
    next_st.phi = tick;
    // Free-running divider for the converter clock [R25]
    next_st.div_cnt = tick ? 3'h0 : st.div_cnt + 3'h1;
    if (!st.c0.conversion_go_flag) begin
      // Clearing go stops every mode at once [R4] [R5] [R13]
      next_st.state = ST_IDLE;
    end else begin
      unique case (st.state)
        ST_IDLE: begin
          // Software trigger starts now, otherwise arm [R2] [R3]
          next_st.state = st.c0.trigger_kind_select ? ST_WAIT : ST_CONV;
          next_st.tick_cnt = 7'h00;
          next_st.idx = 3'h0;
          next_st.prio_phase = 1'b1;
          next_st.oidx = prio_last + 3'h1;
          next_st.chan = first_ch;
        end
        ST_WAIT: begin
          if (trig) begin
            next_st.state = ST_CONV; // [R3]
            next_st.tick_cnt = 7'h00;
          end
        end
        ST_CONV: begin
          if (retrig) begin
            // Abort and begin the run again
            next_st.tick_cnt = 7'h00; // [R22]
            next_st.idx = 3'h0;
            next_st.chan = first_ch;
          end else if (conv_end) begin
            next_st.tick_cnt = 7'h00;
            next_st.res[dest] = res_val; // [R10] [R11]
            next_st.dma_req = st.c3.dma_result_mode;
            // Per-conversion with DMA, else single or end of sweep
            next_st.irq = st.c3.dma_result_mode || last_of_run; // [R7] [R8] [R9]
            unique case (st.c0.mode)
              `MODE_SWEEP, `MODE_RSWEEP0: begin
                // Step through the group, wrap in repeated sweep 0 [R13]
                next_st.idx = st.idx == sweep_last ? 3'h0 : st.idx + 3'h1;
                next_st.chan = {1'b0, next_st.idx};
              end
              `MODE_RSWEEP1: begin
                // All eight inputs, priority set before each other [R14] [R17]
                if (st.prio_phase && st.idx != prio_last) begin
                  next_st.idx = st.idx + 3'h1;
                  next_st.chan = {1'b0, next_st.idx};
                end else if (st.prio_phase) begin
                  next_st.prio_phase = 1'b0;
                  next_st.chan = {1'b0, st.oidx};
                end else begin
                  next_st.prio_phase = 1'b1;
                  next_st.idx = 3'h0;
                  next_st.chan = 4'h0;
                  next_st.oidx = st.oidx == `LAST_CH ? prio_last + 3'h1 : st.oidx + 3'h1;
                end
              end
              default: begin
                next_st.chan = st.chan; // Repeat mode keeps its input [R5]
              end
            endcase
            if (last_of_run) begin
              // Done: clear go under software trigger, else re-arm [R4]
              next_st.state = st.c0.trigger_kind_select ? ST_WAIT : ST_IDLE;
              if (!st.c0.trigger_kind_select) begin
                next_st.c0.conversion_go_flag = 1'b0;
              end
            end
          end else if (tick) begin
            next_st.tick_cnt = st.tick_cnt + 7'h01;
          end
        end
        default: next_st.state = ST_IDLE;
      endcase
    end
    // Data phase write; a software write of go wins over the clear
    if (st.bus_valid && st.bus_wr) begin
      unique case (st.bus_idx)
        `IDX_CTRL0: next_st.c0 = hwdata_in[$bits(ctrl0_s)-1:0];
        `IDX_CTRL1: next_st.c1 = hwdata_in[$bits(ctrl1_s)-1:0];
        `IDX_CTRL2: next_st.c2 = hwdata_in[$bits(ctrl2_s)-1:0];
        `IDX_CTRL3: next_st.c3 = hwdata_in[$bits(ctrl3_s)-1:0];
        default: next_st.c3 = next_st.c3; // Results and holes ignore writes
      endcase
    end
    // Address phase: latch request and prepare read data
    next_st.bus_valid = hsel_in && htrans_in[1] && hready_in;
    next_st.bus_wr = hwrite_in;
    next_st.bus_idx = ridx;
    next_st.hrdata = 32'h0;
    if (hsel_in && htrans_in[1] && hready_in && !hwrite_in) begin
      if (ridx == `IDX_CTRL0) begin
        next_st.hrdata = {20'h0, st.state == ST_CONV, st.c0};
      end else if (ridx == `IDX_CTRL1) begin
        next_st.hrdata = {26'h0, st.c1};
      end else if (ridx == `IDX_CTRL2) begin
        next_st.hrdata = {30'h0, st.c2};
      end else if (ridx == `IDX_CTRL3) begin
        next_st.hrdata = {31'h0, st.c3};
      end else if (ridx <= `IDX_RES7) begin
        next_st.hrdata = {22'h0, st.res[3'(ridx - `IDX_RES0)]};
      end
    end
  end

  //--------------------------------------------------------------
  // State register
  //--------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs; the slave never waits and always answers OKAY
  assign hrdata_out = st.hrdata;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign conv_clock_out = st.phi;
  assign conv_channel_out = st.chan;
  assign converting_out = st.state == ST_CONV;
  assign ladder_reference_connect_out = st.c1.ladder_reference_connect;
  assign sample_hold_out = st.c2.sample_hold;
  assign irq_out = st.irq;
  assign dma_req_out = st.dma_req;

  //--------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------
  a_sw_start: assert property (@(posedge clock_in) disable iff (rst_in) // [R2]
    st.state == ST_IDLE && st.c0.conversion_go_flag && !st.c0.trigger_kind_select
    |=> converting_out) else $error("software start did not convert");
  a_trig_start: assert property (@(posedge clock_in) disable iff (rst_in) // [R3]
    st.state == ST_WAIT && st.c0.conversion_go_flag && trig |=> converting_out)
    else $error("trigger did not start conversion");
  a_wait_hold: assert property (@(posedge clock_in) disable iff (rst_in) // [R3]
    st.state == ST_WAIT && !trig |=> !converting_out)
    else $error("converted without trigger");
  a_single_stop: assert property (@(posedge clock_in) disable iff (rst_in) // [R4]
    conv_end && st.c0.conversion_go_flag && !retrig && last_of_run
    && !st.c0.trigger_kind_select && !wr_ctrl0 |=> !st.c0.conversion_go_flag ##1 !converting_out)
    else $error("single run did not stop");
  a_go_clear: assert property (@(posedge clock_in) disable iff (rst_in) // [R5] [R13]
    !st.c0.conversion_go_flag |=> !converting_out)
    else $error("kept converting with go cleared");
  a_dma_irq: assert property (@(posedge clock_in) disable iff (rst_in) // [R9]
    conv_end && !retrig && st.c0.conversion_go_flag && st.c3.dma_result_mode
    |=> irq_out && dma_req_out) else $error("missing request in DMA mode");
  a_repeat_quiet: assert property (@(posedge clock_in) disable iff (rst_in) // [R8]
    !st.c3.dma_result_mode && st.c0.mode != `MODE_SINGLE && st.c0.mode != `MODE_SWEEP
    |=> !irq_out) else $error("interrupt in repeat mode");
  a_dma_dest: assert property (@(posedge clock_in) disable iff (rst_in) // [R10]
    conv_end && !retrig && st.c0.conversion_go_flag && st.c3.dma_result_mode
    |=> st.res[0] == $past(res_val)) else $error("DMA result not in register 0");
  a_rs1_ignore: assert property (@(posedge clock_in) disable iff (rst_in) // [R16]
    st.state == ST_CONV && st.c0.mode == `MODE_RSWEEP1 && trig && !conv_end
    && st.c0.conversion_go_flag |=> st.chan == $past(st.chan))
    else $error("trigger disturbed repeated sweep 1");
  a_retrig: assert property (@(posedge clock_in) disable iff (rst_in) // [R22]
    retrig && st.c0.conversion_go_flag |=> st.tick_cnt == 7'h00 && converting_out)
    else $error("retrigger did not restart");
endmodule

// ===== sim/adc_far_side.sv
/*
  Far-side model of the sequencer: analogue core code source,
  trigger pin with pull-up and motor timer event source.
  Assumes the bench pulses the fire inputs just after a rising edge.
*/
`timescale 1ns/10ps
module adc_far_side (
  input wire logic clock_in,
  input wire logic [3:0] conv_channel_in,
  input wire logic converting_in,
  input wire logic fire_edge_in,
  input wire logic fire_timer_in,
  output logic [9:0] conv_data_out,
  output logic external_trigger_pin_out,
  output logic motor_timer_counter_out
);
  // ------------------------------
  // Code and trigger sources
  // ------------------------------
  logic [9:0] last_code = 10'h000; // Last code shown
  logic [1:0] low_cnt = 2'h0; // Cycles left with the pin pulled low
  // Outside conversions the core shows the inverse, so a late sample is caught
  always_comb begin
    conv_data_out = converting_in ? {conv_channel_in, 6'h2d} : ~last_code;
    external_trigger_pin_out = (low_cnt == 2'h0); // Pulled high at idle
  end
  // Falling edge held two cycles; timer event one cycle per request
  always @(posedge clock_in) begin
    if (converting_in) begin
      last_code <= {conv_channel_in, 6'h2d};
    end
    if (fire_edge_in) begin
      low_cnt <= 2'h2;
    end else if (low_cnt != 2'h0) begin
      low_cnt <= low_cnt - 2'h1;
    end
    motor_timer_counter_out <= fire_timer_in;
  end
endmodule

// ===== sim/adc_mode_sequencer_test.sv
/*
  Self-checking bench of the mode sequencer over AHB-Lite.
  Assumes the far-side model supplies codes {channel, 6'h2d}.
*/
`timescale 1ns/10ps
`include "adc_seq_cfg.svh"
`define CHK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin mismatches++; \
  $display("[FAIL] %s expected %h seen %h", what, exp, got); end end
module adc_mode_sequencer_test;
  // ------------------------------
  // Signals
  // ------------------------------
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0, fire_e = 1'b0, fire_t = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic hready, hresp, ext_pin, tmr, cclk, conv, ladder, sh, irq, dma;
  logic [3:0] chan, prev_ch = 4'h0;
  logic [9:0] cdata;
  logic prev_conv = 1'b0;
  logic [3:0] seq_log[$], exp_q[$];
  int mismatches = 0, check_count = 0, irq_cnt = 0, dma_cnt = 0, cycles = 0, t0;
  logic [3:0] rat[6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8}; // Divider ratios per code
  always #2.5 clock_in = ~clock_in;
  adc_mode_sequencer i_adc_mode_sequencer (.clock_in(clock_in), .rst_in(rst_in), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .external_trigger_pin_in(ext_pin), .motor_timer_counter_in(tmr), .conv_data_in(cdata),
    .conv_clock_out(cclk), .conv_channel_out(chan), .converting_out(conv),
    .ladder_reference_connect_out(ladder), .sample_hold_out(sh), .irq_out(irq), .dma_req_out(dma));
  adc_far_side i_adc_far_side (.clock_in(clock_in), .conv_channel_in(chan), .converting_in(conv),
    .fire_edge_in(fire_e), .fire_timer_in(fire_t), .conv_data_out(cdata),
    .external_trigger_pin_out(ext_pin), .motor_timer_counter_out(tmr));
  // ------------------------------
  // Tasks
  // ------------------------------
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Pulses, channel order and the hang limit; a hang counts as a mismatch
  always @(posedge clock_in) begin
    cycles++;
    if (irq === 1'b1) irq_cnt++;
    if (dma === 1'b1) dma_cnt++;
    if (conv === 1'b1 && (prev_conv !== 1'b1 || chan !== prev_ch)) seq_log.push_back(chan);
    prev_conv <= conv;
    prev_ch <= chan;
    if (cycles > 30000) begin
      mismatches++;
      finish_test();
    end
  end
  // One single transfer; values are taken at the edge where ready is high
  task bus_xfer(input logic [3:0] idx, input logic wr, input logic [31:0] wd, output logic [31:0] rv);
    hsel <= 1'b1;
    haddr <= {26'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    // Address phase stands until ready is seen high at a rising edge
    do @(posedge clock_in); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    // Data phase stands until ready again; read data taken at that edge
    do @(posedge clock_in); while (hready !== 1'b1);
    rv = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask
  task wr(input logic [3:0] idx, input logic [31:0] d);
    logic [31:0] x;
    bus_xfer(idx, 1'b1, d, x);
  endtask
  task rdchk(input logic [3:0] idx, input logic [31:0] exp);
    logic [31:0] x;
    bus_xfer(idx, 1'b0, 32'h0, x);
    `CHK($sformatf("reg %0d", idx), exp, x)
  endtask
  function automatic logic [31:0] code(input logic [3:0] ch);
    return {22'h0, ch, 6'h2d};
  endfunction
  // Clear counters and logs, then write control word 0
  task go(input logic [31:0] c0);
    irq_cnt = 0;
    dma_cnt = 0;
    seq_log.delete();
    exp_q.delete();
    wr(`IDX_CTRL0, c0);
  endtask
  task wait_irq(input int n);
    while (irq_cnt < n) @(negedge clock_in);
    @(posedge clock_in);
  endtask
  task pulse_t;
    fire_t <= 1'b1;
    @(posedge clock_in);
    fire_t <= 1'b0;
  endtask
  task pulse_e;
    fire_e <= 1'b1;
    @(posedge clock_in);
    fire_e <= 1'b0;
  endtask
  task chk_seq;
    for (int i = 0; i < exp_q.size(); i++) `CHK("order", exp_q[i], seq_log[i])
  endtask
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    @(posedge clock_in);
    rdchk(`IDX_CTRL0, 32'h0);
    rdchk(4'hc, 32'h0); // Unmapped word reads zero
    wr(`IDX_RES7, 32'h3ff);
    rdchk(`IDX_RES7, 32'h0); // Result words are read-only
    wr(`IDX_CTRL1, 32'h30); // Ladder on before go
    go(32'h85);
    wait_irq(1);
    repeat (4) @(posedge clock_in);
    `CHK("irqs", 1, irq_cnt)
    `CHK("ladder", 1'b1, ladder)
    rdchk(`IDX_CTRL0, 32'h05);
    rdchk(`IDX_RES0 + 4'h5, code(4'h5));
    wr(`IDX_CTRL1, 32'h20); // Control rewritten only while stopped
    go(32'h83);
    wait_irq(1);
    rdchk(`IDX_RES0 + 4'h3, code(4'h3) >> 2);
    wr(`IDX_CTRL1, 32'h34); // Extended input only in single mode
    go(32'h80);
    wait_irq(1);
    rdchk(`IDX_RES0, code(`CH_EXT0));
    wr(`IDX_CTRL1, 32'h31);
    go(32'h90);
    wait_irq(1);
    repeat (4) @(posedge clock_in);
    for (int k = 0; k < 4; k++) exp_q.push_back(4'(k));
    chk_seq();
    `CHK("irqs", 1, irq_cnt)
    `CHK("busy", 1'b0, conv)
    for (int k = 0; k < 4; k++) rdchk(`IDX_RES0 + 4'(k), code(4'(k)));
    go(32'h8a);
    repeat (200) @(posedge clock_in);
    `CHK("irqs", 0, irq_cnt)
    `CHK("busy", 1'b1, conv)
    wr(`IDX_CTRL0, 32'h0a);
    repeat (3) @(posedge clock_in);
    `CHK("busy", 1'b0, conv)
    rdchk(`IDX_RES0 + 4'h2, code(4'h2));
    wr(`IDX_CTRL1, 32'h30);
    wr(`IDX_CTRL3, 32'h1);
    go(32'h98);
    wait_irq(4);
    `CHK("dma", 4, dma_cnt)
    wr(`IDX_CTRL0, 32'h0);
    repeat (3) @(posedge clock_in);
    wr(`IDX_CTRL3, 32'h0); // Touched only once stopped
    exp_q = '{4'h0, 4'h1, 4'h0, 4'h1};
    chk_seq();
    rdchk(`IDX_RES0, code(4'h1));
    wr(`IDX_CTRL2, 32'h3); // Timer trigger, sample-hold on
    go(32'he0);
    repeat (5) @(posedge clock_in);
    `CHK("wait", 1'b0, conv)
    `CHK("hold", 1'b1, sh)
    pulse_t();
    repeat (75) @(posedge clock_in);
    pulse_t();
    repeat (720) @(posedge clock_in);
    wr(`IDX_CTRL0, 32'h0);
    for (int k = 1; k < 8; k++) begin
      exp_q.push_back(4'h0);
      exp_q.push_back(4'(k));
    end
    chk_seq();
    `CHK("irqs", 0, irq_cnt)
    wr(`IDX_CTRL2, 32'h0);
    wr(`IDX_CTRL1, 32'h33);
    go(32'hd0);
    pulse_e();
    repeat (120) @(posedge clock_in);
    pulse_e();
    wait_irq(1);
    exp_q = '{4'h0, 4'h1, 4'h2};
    for (int k = 0; k < 8; k++) exp_q.push_back(4'(k));
    chk_seq();
    bus_xfer(`IDX_CTRL0, 1'b0, 32'h0, rd);
    `CHK("go kept", 32'h80, rd & 32'h80)
    wr(`IDX_CTRL0, 32'h0);
    wr(`IDX_CTRL1, 32'h20);
    for (int i = 0; i < 6; i++) begin
      go({21'h0, 3'(i), 8'h80});
      @(negedge clock_in);
      while (cclk !== 1'b1) @(negedge clock_in);
      t0 = cycles;
      @(negedge clock_in);
      while (cclk !== 1'b1) @(negedge clock_in);
      `CHK("tick gap", rat[i], 4'(cycles - t0))
      wait_irq(1);
    end
    finish_test();
  end
endmodule
